/* File: logic/scpw_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the modulator.
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef SCPW_REGS_SVH
`define SCPW_REGS_SVH
// ==========================================================================
// Register byte offsets
`define SCPW_OFF_CTL 8'h00
`define SCPW_OFF_CKS 8'h04
`define SCPW_OFF_PRDH 8'h08
`define SCPW_OFF_PRDL 8'h0c
`define SCPW_OFF_DUTYH0 8'h10
`define SCPW_OFF_DUTYL0 8'h14
`define SCPW_OFF_STAT 8'h40
`define SCPW_OFF_CLR 8'h44
`define SCPW_OFF_IEN 8'h48
`define SCPW_OFF_PINSEL 8'h4c
// ==========================================================================
// Field positions
`define SCPW_CTL_EN_BIT 7
`define SCPW_CTL_OM_LSB 4
`define SCPW_CTL_DZ_LSB 0
`define SCPW_CKS_LSB 4
`define SCPW_STAT_PEND_BIT 0
// ==========================================================================
// Reset values
`define SCPW_PRD_RST 16'hffff
`define SCPW_DUTY_RST 16'h8000
// ==========================================================================
// Timing: fast oscillator and its double, given in MHz; system clock 40 MHz.
`define SCPW_SYS_MHZ 40
`define SCPW_FAST_INTERNAL_RC_OSC_MHZ 16
`define SCPW_FIRC2_MHZ 32
`define SCPW_ACC_W 6
`endif

/* File: logic/scpw_pkg.sv */
// Purpose: Types shared by the six-channel modulator.
// Assumes: Nothing beyond the register header.
// Notes: Holds types only.
`default_nettype none
package scpw_pkg;
  typedef enum logic [1:0] {
    SCPW_MODE0 = 2'b00,
    SCPW_MODE1 = 2'b01,
    SCPW_MODE2 = 2'b10,
    SCPW_MODE3 = 2'b11
  } scpw_mode_t;
  typedef struct packed {
    logic ch0_positive_output;
    logic ch0_negative_output;
    logic [4:0] single_channel_output;
  } scpw_pins_t;
endpackage
`default_nettype wire

/* File: logic/scpw_top.sv */
// Purpose: Six-channel 16-bit modulator with non-overlap pair on channel 0, AXI4-Lite slave.
// Assumes: aclk at 40 MHz; oscillator rates reached by fractional enables on aclk.
// Notes: The 16 MHz and 32 MHz sources are approximated by a phase accumulator, so their edges jitter.
// Functional notes
// [RULE1] Six duty words, one shared period word.
// [RULE2] Clock from system, 16 MHz or 32 MHz.
// [RULE3] Full 16-bit compares, 65536 duty steps.
// [RULE4] High byte direct, low byte via buffer.
// [RULE5] High write commits both; high read latches.
// [RULE6] Software writes low first, reads high first.
// [RULE7] Enable clear holds all channels cleared; the code drives the inverted channel 0 pins high in Mode1 to Mode3.
// [RULE8] Output drops low when counter equals duty.
// [RULE9] New period and duty apply immediately.
// [RULE10] One shared flag set at period end.
// [RULE11] Only channel 0 has complementary non-overlap pair.
// [RULE12] Four output modes, Mode0 after reset.
// [RULE13] Non-overlap 0 to 15 modulator clocks.
// [RULE14] Channels 1-5 reach pins only when selected.
// [RULE15] Flag set at rollover, cleared by software.
// [RULE16] Mode field 00..11 selects Mode0..Mode3.
// [RULE17] Select 0x system, 10 16 MHz, 11 32 MHz.
// [RULE18] Counter runs zero to period; outputs high at start.
// [RULE19] Mode0: positive follows, negative complements, rises delayed.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scpw_regs.svh"
module scpw_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output scpw_pkg::scpw_pins_t pins,
  output logic irq
);
  import scpw_pkg::*;
  // ========================================================================
  // Register state
  logic [15:0] shared_period_word;
  logic [15:0] duty_reg [6];
  logic [7:0] hold_reg;
  logic modulator_run_enable;
  scpw_mode_t ch0_output_mode_sel;
  logic [3:0] ch0_nonoverlap_width;
  logic [1:0] modulator_clock_select;
  logic period_end_flag;
  logic irq_en_reg;
  logic [4:0] pin_sel_reg;
  logic [15:0] base_cnt_reg;
  logic [`SCPW_ACC_W-1:0] acc_reg;
  logic tick;
  logic wrap;
  // ========================================================================
  // AXI4-Lite write path: address and data are held until both are present.
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign do_wr = aw_full && w_full && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;
  // Capture channel payloads independently so either order is accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Decode of the committed write; unmapped offsets are accepted and ignored.
  logic wr_lane0;
  logic [7:0] wb;
  assign wr_lane0 = do_wr && w_strb[0];
  assign wb = w_data[7:0];
  // Control fields written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      modulator_run_enable <= 1'b0;
      ch0_output_mode_sel <= SCPW_MODE0; // RULE12
      ch0_nonoverlap_width <= 4'h0;
      modulator_clock_select <= 2'b00;
      irq_en_reg <= 1'b0;
      pin_sel_reg <= 5'h00;
    end else if (wr_lane0) begin
      case (aw_addr)
        `SCPW_OFF_CTL: begin
          modulator_run_enable <= wb[`SCPW_CTL_EN_BIT];
          ch0_output_mode_sel <= scpw_mode_t'(wb[`SCPW_CTL_OM_LSB +: 2]); // RULE16
          ch0_nonoverlap_width <= wb[`SCPW_CTL_DZ_LSB +: 4]; // RULE13
        end
        `SCPW_OFF_CKS: modulator_clock_select <= wb[`SCPW_CKS_LSB +: 2];
        `SCPW_OFF_IEN: irq_en_reg <= wb[`SCPW_STAT_PEND_BIT];
        `SCPW_OFF_PINSEL: pin_sel_reg <= wb[4:0];
        default: ;
      endcase
    end
  end
  // Byte-buffered words: low writes go to the holding buffer, high writes commit.
  // The same buffer is loaded by high-byte reads, so it is shared in both directions.
  logic [2:0] rd_idx;
  logic rd_hi_prd, rd_hi_duty;
  logic rd_go;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= 8'h00;
      shared_period_word <= `SCPW_PRD_RST;
      for (int i = 0; i < 6; i++) begin
        duty_reg[i] <= `SCPW_DUTY_RST;
      end
    end else begin
      if (rd_go && rd_hi_prd) begin
        hold_reg <= shared_period_word[7:0]; // RULE5
      end else if (rd_go && rd_hi_duty) begin
        hold_reg <= duty_reg[rd_idx][7:0]; // RULE5
      end
      if (wr_lane0) begin
        if (aw_addr == `SCPW_OFF_PRDL) begin
          hold_reg <= wb; // RULE4
        end else if (aw_addr == `SCPW_OFF_PRDH) begin
          shared_period_word <= {wb, hold_reg}; // RULE5 RULE9
        end
        for (int i = 0; i < 6; i++) begin
          if (aw_addr == 8'(`SCPW_OFF_DUTYL0 + 8 * i)) begin
            hold_reg <= wb; // RULE4
          end
          if (aw_addr == 8'(`SCPW_OFF_DUTYH0 + 8 * i)) begin
            duty_reg[i] <= {wb, hold_reg}; // RULE1 RULE5 RULE9
          end
        end
      end
    end
  end
  // ========================================================================
  // AXI4-Lite read path: one cycle from address to data.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;
  assign rd_hi_prd = (s_axi_araddr == `SCPW_OFF_PRDH);
  always_comb begin
    rd_hi_duty = 1'b0;
    rd_idx = 3'd0;
    for (int i = 0; i < 6; i++) begin
      if (s_axi_araddr == 8'(`SCPW_OFF_DUTYH0 + 8 * i)) begin
        rd_hi_duty = 1'b1;
        rd_idx = 3'(i);
      end
    end
  end
  // Read mux; low-byte reads return the buffer, unmapped offsets read zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `SCPW_OFF_CTL: rd_mux = {24'h0, modulator_run_enable, 1'b0, ch0_output_mode_sel,
                               ch0_nonoverlap_width};
      `SCPW_OFF_CKS: rd_mux = {26'h0, modulator_clock_select, 4'h0};
      `SCPW_OFF_PRDH: rd_mux = {24'h0, shared_period_word[15:8]};
      `SCPW_OFF_PRDL: rd_mux = {24'h0, hold_reg}; // RULE4
      `SCPW_OFF_STAT: rd_mux = {31'h0, period_end_flag};
      `SCPW_OFF_IEN: rd_mux = {31'h0, irq_en_reg};
      `SCPW_OFF_PINSEL: rd_mux = {27'h0, pin_sel_reg};
      default: begin
        if (rd_hi_duty) begin
          rd_mux = {24'h0, duty_reg[rd_idx][15:8]};
        end
        for (int i = 0; i < 6; i++) begin
          if (s_axi_araddr == 8'(`SCPW_OFF_DUTYL0 + 8 * i)) begin
            rd_mux = {24'h0, hold_reg}; // RULE4
          end
        end
      end
    endcase
  end
  // Read data register and valid handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  // ========================================================================
  // Modulator clock enable. A phase accumulator adds the selected rate each
  // aclk; an overflow is one modulator tick. System clock ticks every cycle.
  logic [`SCPW_ACC_W-1:0] step;
  logic [`SCPW_ACC_W:0] acc_sum;
  always_comb begin
    case (modulator_clock_select)
      2'b10: step = `SCPW_ACC_W'(`SCPW_FAST_INTERNAL_RC_OSC_MHZ); // RULE17
      2'b11: step = `SCPW_ACC_W'(`SCPW_FIRC2_MHZ); // RULE17
      default: step = `SCPW_ACC_W'(`SCPW_SYS_MHZ); // RULE17
    endcase
  end
  assign acc_sum = {1'b0, acc_reg} + {1'b0, step};
  assign tick = (acc_sum >= (`SCPW_ACC_W + 1)'(`SCPW_SYS_MHZ)); // RULE2
  // Accumulator keeps the fractional phase of the selected source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= '0;
    end else if (tick) begin
      acc_reg <= `SCPW_ACC_W'(acc_sum - (`SCPW_ACC_W + 1)'(`SCPW_SYS_MHZ));
    end else begin
      acc_reg <= acc_sum[`SCPW_ACC_W-1:0];
    end
  end
  // ========================================================================
  // Base counter from zero to period; a shortened period wraps at once.
  assign wrap = tick && (base_cnt_reg >= shared_period_word); // RULE3 RULE9
  always_ff @(posedge aclk) begin
    if (!aresetn || !modulator_run_enable) begin
      base_cnt_reg <= 16'h0000; // RULE7
    end else if (wrap) begin
      base_cnt_reg <= 16'h0000; // RULE18
    end else if (tick) begin
      base_cnt_reg <= base_cnt_reg + 16'h0001; // RULE18
    end
  end
  // Channel waveforms: high at period start, low on duty match.
  logic [5:0] wave_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !modulator_run_enable) begin
      wave_reg <= 6'h00; // RULE7
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (base_cnt_reg == duty_reg[i]) begin
          wave_reg[i] <= 1'b0; // RULE8 RULE3
        end else if (base_cnt_reg == 16'h0000) begin
          wave_reg[i] <= 1'b1; // RULE18
        end
      end
    end
  end
  // Period-end flag; hardware set wins over a software clear.
  logic clr_hit;
  assign clr_hit = wr_lane0 && (aw_addr == `SCPW_OFF_CLR) && wb[`SCPW_STAT_PEND_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_end_flag <= 1'b0;
    end else if (wrap && modulator_run_enable) begin
      period_end_flag <= 1'b1; // RULE10 RULE15
    end else if (clr_hit) begin
      period_end_flag <= 1'b0; // RULE15
    end
  end
  assign irq = period_end_flag && irq_en_reg;
  // ========================================================================
  // Channel 0 non-overlap: each rising edge of either side waits Tnov ticks.
  logic [3:0] nov_cnt_reg;
  logic w0_prev;
  logic p_raw, n_raw, p_out, n_out;
  always_ff @(posedge aclk) begin
    if (!aresetn || !modulator_run_enable) begin
      nov_cnt_reg <= 4'h0;
      w0_prev <= 1'b0;
    end else begin
      w0_prev <= wave_reg[0];
      if (wave_reg[0] != w0_prev) begin
        nov_cnt_reg <= (tick && ch0_nonoverlap_width != 4'h0) ?
          ch0_nonoverlap_width - 4'h1 : ch0_nonoverlap_width; // RULE13
      end else if (tick && nov_cnt_reg != 4'h0) begin
        nov_cnt_reg <= nov_cnt_reg - 4'h1;
      end
    end
  end
  // Mode0 pair; other modes invert one or both sides, dead time kept.
  logic busy;
  assign busy = (nov_cnt_reg != 4'h0) || (wave_reg[0] != w0_prev && ch0_nonoverlap_width != 4'h0);
  assign p_raw = wave_reg[0] && !busy; // RULE19 RULE11
  assign n_raw = !wave_reg[0] && !busy && modulator_run_enable; // RULE19
  always_comb begin
    case (ch0_output_mode_sel)
      SCPW_MODE0: begin p_out = p_raw; n_out = n_raw; end // RULE12
      SCPW_MODE1: begin p_out = !p_raw; n_out = !n_raw; end
      SCPW_MODE2: begin p_out = p_raw; n_out = !n_raw; end
      SCPW_MODE3: begin p_out = !p_raw; n_out = n_raw; end
      default: begin p_out = p_raw; n_out = n_raw; end
    endcase
  end
  // Output pins registered; single outputs gated by the pin-function select.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins <= '0;
    end else begin
      pins.ch0_positive_output <= p_out;
      pins.ch0_negative_output <= n_out;
      pins.single_channel_output <= wave_reg[5:1] & pin_sel_reg; // RULE14 RULE11
    end
  end
  // ========================================================================
  // Checks.
  property p_stop_clears;
    @(posedge aclk) disable iff (!aresetn) !modulator_run_enable |=> base_cnt_reg == 16'h0000;
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("counter not held"); // RULE7
  property p_match_low;
    @(posedge aclk) disable iff (!aresetn)
      modulator_run_enable && base_cnt_reg == duty_reg[1] ##1 modulator_run_enable
      |-> !wave_reg[1];
  endproperty
  a_match_low: assert property (p_match_low) else $error("no low on match"); // RULE8
  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn) wrap && modulator_run_enable |=> period_end_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set"); // RULE10
  property p_flag_clr;
    @(posedge aclk) disable iff (!aresetn) clr_hit && !wrap |=> !period_end_flag;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // RULE15
  property p_hi_commit;
    @(posedge aclk) disable iff (!aresetn)
      wr_lane0 && aw_addr == `SCPW_OFF_PRDH |=> shared_period_word == {$past(wb), $past(hold_reg)};
  endproperty
  a_hi_commit: assert property (p_hi_commit) else $error("period not committed"); // RULE5
  property p_sys_tick;
    @(posedge aclk) disable iff (!aresetn) modulator_clock_select[1] == 1'b0 |-> tick;
  endproperty
  a_sys_tick: assert property (p_sys_tick) else $error("system rate lost"); // RULE17
  property p_pin_gate;
    @(posedge aclk) disable iff (!aresetn) !pin_sel_reg[0] |=> !pins.single_channel_output[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin not gated"); // RULE14
  property p_no_overlap;
    @(posedge aclk) disable iff (!aresetn) ch0_output_mode_sel == SCPW_MODE0
      |=> !(pins.ch0_positive_output && pins.ch0_negative_output);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair overlaps"); // RULE19
endmodule
`default_nettype wire

/* File: verification/scpw_load.sv */
// Purpose: Load on the modulator pins; counts cycles where both pair switches conduct.
// Assumes: Pins are registered levels sampled on aclk.
// Notes: Any count above zero in a normal pair mode means shoot-through.
`timescale 1ns/1ps
`default_nettype none
module scpw_load (
  input wire logic aclk,
  input wire logic clr,
  input wire scpw_pkg::scpw_pins_t pins,
  output var int overlap_count
);
  import scpw_pkg::*;
  // ==========================================================================
  // Overlap monitor
  // Both switches of a half bridge on at once would short the supply.
  always @(posedge aclk) begin
    if (clr) begin
      overlap_count <= 0;
    end else if (pins.ch0_positive_output === 1'b1 && pins.ch0_negative_output === 1'b1) begin
      overlap_count <= overlap_count + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/scpw_tb.sv */
// Purpose: Self-checking bench for the six-channel modulator.
// Assumes: Period 19 on the system clock gives a 20-cycle waveform.
// Notes: Pin counts are taken over two whole periods after two settling periods.
`timescale 1ns/1ps
`default_nettype none
`include "scpw_regs.svh"
module testbench;
  import scpw_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  scpw_pins_t pins;
  logic load_clr = 1'b0;
  int overlap_count;
  int n_mismatch = 0;
  int check_count = 0;
  int c_pos, c_neg;
  int c_s[5];
  // ==========================================================================
  // Clock, design and load
  always #12.5 aclk = ~aclk;
  scpw_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .pins, .irq);
  scpw_load u_load (.aclk(aclk), .clr(load_clr), .pins(pins), .overlap_count(overlap_count));
  // ==========================================================================
  // Reporting
  task give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task timed_out;
    n_mismatch++;
    $display("mismatch at %0t: wait ran out", $time);
    give_verdict();
  endtask
  task check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task check_cyc(input int got, input int exp);
    check_count++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch at %0t: counted %0d expected %0d", $time, got, exp);
    end
  endtask
  // ==========================================================================
  // Bus master: each channel is released at the edge where it is taken.
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        check_word({30'h0, s_axi_bresp}, 32'h0);
      end
    end
    s_axi_bready <= 1'b0;
    if (!done) timed_out();
  endtask
  task axi_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 100 && !done; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        done = 1'b1;
        check_word({30'h0, s_axi_rresp}, 32'h0);
      end
    end
    s_axi_rready <= 1'b0;
    if (!done) timed_out();
  endtask
  // Words go low byte first on writes and high byte first on reads.
  task wr16(input logic [7:0] hi, input logic [15:0] v);
    axi_write(hi + 8'h04, {24'h0, v[7:0]});
    axi_write(hi, {24'h0, v[15:8]});
  endtask
  task chk16(input logic [7:0] hi, input logic [15:0] exp);
    logic [31:0] h, l;
    axi_read(hi, h);
    axi_read(hi + 8'h04, l);
    check_word({16'h0, h[7:0], l[7:0]}, {16'h0, exp});
  endtask
  task chk_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    check_word(d, exp);
  endtask
  // Settle two periods, then count high cycles over two periods.
  task count_pins;
    repeat (40) @(posedge aclk);
    load_clr <= 1'b1;
    @(posedge aclk);
    load_clr <= 1'b0;
    c_pos = 0;
    c_neg = 0;
    c_s = '{0, 0, 0, 0, 0};
    repeat (40) begin
      @(posedge aclk);
      c_pos += int'(pins.ch0_positive_output === 1'b1);
      c_neg += int'(pins.ch0_negative_output === 1'b1);
      for (int i = 0; i < 5; i++) c_s[i] += int'(pins.single_channel_output[i] === 1'b1);
    end
  endtask
  task wait_rise(output int n);
    n = 0;
    while (pins.ch0_positive_output !== 1'b0) begin
      @(posedge aclk);
      if (++n > 400) timed_out();
    end
    while (pins.ch0_positive_output !== 1'b1) begin
      @(posedge aclk);
      if (++n > 400) timed_out();
    end
  endtask
  // ==========================================================================
  // Scenarios
  task t_reset;
    check_word({31'h0, pins.ch0_positive_output}, 32'h0);
    chk16(`SCPW_OFF_PRDH, `SCPW_PRD_RST);
    chk16(8'h38, `SCPW_DUTY_RST);
    chk_reg(`SCPW_OFF_CTL, 32'h0);
    chk_reg(8'h50, 32'h0);
    $display("reset values done");
  endtask
  task t_buffer;
    wr16(`SCPW_OFF_PRDH, 16'h0013);
    axi_write(`SCPW_OFF_PRDL, 32'h22); // A lone low byte must stay in the buffer.
    chk16(`SCPW_OFF_PRDH, 16'h0013);
    $display("byte buffer done");
  endtask
  task t_modes;
    int ep[4];
    int en[4];
    ep = '{10, 30, 10, 30};
    en = '{30, 10, 10, 30};
    wr16(`SCPW_OFF_DUTYH0, 16'h0005);
    for (int m = 0; m < 4; m++) begin
      axi_write(`SCPW_OFF_CTL, 32'h80 | (m << 4));
      count_pins();
      check_cyc(c_pos, ep[m]);
      check_cyc(c_neg, en[m]);
    end
    axi_write(`SCPW_OFF_CTL, 32'h83);
    count_pins();
    check_cyc(c_pos, 4);
    check_cyc(c_neg, 24);
    check_cyc(overlap_count, 0);
    $display("output modes done");
  endtask
  task t_singles;
    wr16(8'h18, 16'h0005);
    wr16(8'h38, 16'h0000);
    count_pins();
    check_cyc(c_s[0], 0);
    axi_write(`SCPW_OFF_PINSEL, 32'h1f);
    count_pins();
    check_cyc(c_s[0], 10);
    check_cyc(c_s[1], 40);
    check_cyc(c_s[4], 0);
    $display("single outputs done");
  endtask
  task t_flag;
    axi_write(`SCPW_OFF_IEN, 32'h1);
    repeat (40) @(posedge aclk);
    chk_reg(`SCPW_OFF_STAT, 32'h1);
    check_word({31'h0, irq}, 32'h1);
    axi_write(`SCPW_OFF_IEN, 32'h0);
    repeat (2) @(posedge aclk);
    check_word({31'h0, irq}, 32'h0);
    axi_write(`SCPW_OFF_CTL, 32'h0);
    axi_write(`SCPW_OFF_CLR, 32'h1);
    chk_reg(`SCPW_OFF_STAT, 32'h0);
    axi_write(`SCPW_OFF_IEN, 32'h1);
    repeat (2) @(posedge aclk);
    check_word({31'h0, irq}, 32'h0);
    $display("period flag done");
  endtask
  task t_enable;
    count_pins();
    check_cyc(c_pos, 0);
    check_cyc(c_s[1], 0);
    chk_reg(`SCPW_OFF_STAT, 32'h0);
    $display("global enable done");
  endtask
  task t_clock;
    int el[4];
    int n;
    el = '{20, 20, 50, 25};
    axi_write(`SCPW_OFF_CTL, 32'h80);
    for (int k = 0; k < 4; k++) begin
      axi_write(`SCPW_OFF_CKS, k << `SCPW_CKS_LSB);
      repeat (3) wait_rise(n);
      check_cyc(n, el[k]);
    end
    $display("clock select done");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_buffer();
    t_modes();
    t_singles();
    t_flag();
    t_enable();
    t_clock();
    give_verdict();
  end
endmodule
`default_nettype wire
